/* File: common/frae_defs.svh */
/*
 * Constants for the file-register add/AND execution datapath: instruction
 * field positions, opcodes, widths, flag bit positions and reset values.
 * Assumes it is included by bare name from design files that need them.
 */
`ifndef FRAE_DEFS_SVH
`define FRAE_DEFS_SVH

// Instruction word layout
`define FRAE_WORD_W     14
`define FRAE_OPC_MSB    13
`define FRAE_OPC_LSB    8
`define FRAE_OPC_W      6
`define FRAE_DEST_BIT   7
`define FRAE_IDX_MSB    6
`define FRAE_IDX_LSB    0
`define FRAE_IDX_W      7

// Opcodes
`define FRAE_SUM_OPC    6'h07
`define FRAE_MASK_OPC   6'h05

// Data path widths
`define FRAE_DATA_W     8
`define FRAE_NIB_W      4
`define FRAE_BYTE_MAX   8'hFF
`define FRAE_NIB_MAX    4'hF
`define FRAE_BYTE_ZERO  8'h00

// Flag preload bit positions
`define FRAE_FLAG_W     3
`define FRAE_FLAG_C     0
`define FRAE_FLAG_DC    1
`define FRAE_FLAG_Z     2

// Reset values
`define FRAE_ACC_RST    8'h00
`define FRAE_ADDR_RST   7'h00
`define FRAE_BIT_RST    1'b0

`endif

/* File: common/frae_pkg.sv */
/*
 * Types shared by the file-register add/AND execution datapath.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package frae_pkg;

	// Operation picked by the decoder for the current word
	typedef enum logic [1:0] {
		FRAE_OP_NONE,
		FRAE_OP_SUM,
		FRAE_OP_MASK
	} frae_op_t;

endpackage

/* File: hw/frae_decode.sv */
/*
 * Instruction decoder for the two file-register operations.
 * Assumes the word is held stable by fetch while its valid is high.
 */
`timescale 1ns/100ps
`include "frae_defs.svh"
module frae_decode
	import frae_pkg::*;
(
	// Instruction in
	input  wire logic                       instr_valid,
	input  wire logic [`FRAE_WORD_W-1:0]    instr_word,
	// Decoded fields
	output frae_op_t                        op,
	output      logic                       dest_file,
	output      logic [`FRAE_IDX_W-1:0]     idx
);

	wire [`FRAE_OPC_W-1:0] opc;
	wire                   hit_sum;
	wire                   hit_mask;

	assign opc = instr_word[`FRAE_OPC_MSB:`FRAE_OPC_LSB];
	assign hit_sum = instr_valid && (opc == `FRAE_SUM_OPC);
	assign hit_mask = instr_valid && (opc == `FRAE_MASK_OPC);

	// Any other word is not ours and decodes as no operation
	assign op = hit_sum ? FRAE_OP_SUM :
		(hit_mask ? FRAE_OP_MASK : FRAE_OP_NONE);

	assign dest_file = instr_word[`FRAE_DEST_BIT];
	assign idx = instr_word[`FRAE_IDX_MSB:`FRAE_IDX_LSB];

endmodule

/* File: hw/frae_core.sv */
/*
 * Execution datapath for the add and AND file-register operations:
 * accumulator, carry, nibble carry and zero flags, and a one-deep
 * write stage toward the data register file with read forwarding.
 * Assumes the register file answers FILE_RADDR combinationally on
 * FILE_RDATA in the same cycle and writes on FILE_WE at the clock.
 */
`timescale 1ns/100ps
`include "frae_defs.svh"
module frae_core
	import frae_pkg::*;
(
	// Clock and reset
	input  wire logic                       CORE_CLK,
	input  wire logic                       RST_N,
	// Instruction from fetch
	input  wire logic                       INSTR_VALID,
	input  wire logic [`FRAE_WORD_W-1:0]    INSTR_WORD,
	// Register file read port
	output      logic [`FRAE_IDX_W-1:0]     FILE_RADDR,
	input  wire logic [`FRAE_DATA_W-1:0]    FILE_RDATA,
	// Register file write port
	output      logic                       FILE_WE,
	output      logic [`FRAE_IDX_W-1:0]     FILE_WADDR,
	output      logic [`FRAE_DATA_W-1:0]    FILE_WDATA,
	// Preload from the rest of the core
	input  wire logic                       ACC_LOAD,
	input  wire logic [`FRAE_DATA_W-1:0]    ACC_LOAD_DATA,
	input  wire logic                       FLAG_LOAD,
	input  wire logic [`FRAE_FLAG_W-1:0]    FLAG_LOAD_DATA,
	// Architectural state
	output      logic [`FRAE_DATA_W-1:0]    ACC,
	output      logic                       CARRY_FLAG,
	output      logic                       NIBBLE_CARRY_FLAG,
	output      logic                       ZERO_FLAG,
	// Completion
	output      logic                       EXEC_DONE
);

	////////////////////////////////////////////////////////////////////
	// Declarations

	frae_op_t                   op;
	logic                       dest_file;
	logic [`FRAE_IDX_W-1:0]     idx;

	logic [`FRAE_DATA_W-1:0]    acc_reg;
	logic [`FRAE_DATA_W-1:0]    acc_next;
	logic                       carry_reg;
	logic                       carry_next;
	logic                       nib_reg;
	logic                       nib_next;
	logic                       zero_reg;
	logic                       zero_next;
	logic                       wr_pend_reg;
	logic [`FRAE_IDX_W-1:0]     wr_addr_reg;
	logic [`FRAE_DATA_W-1:0]    wr_data_reg;
	logic                       done_reg;

	wire                        fwd_hit;
	wire [`FRAE_DATA_W-1:0]     operand;
	wire [`FRAE_DATA_W:0]       sum_wide;
	wire [`FRAE_NIB_W:0]        nib_wide;
	wire [`FRAE_DATA_W-1:0]     mask_res;
	wire [`FRAE_DATA_W-1:0]     result;
	wire                        res_zero;
	wire                        is_sum;
	wire                        is_mask;
	wire                        exec;
	wire                        to_acc;
	wire                        to_file;
	wire [`FRAE_NIB_W-1:0]      acc_low;
	wire [`FRAE_NIB_W-1:0]      opd_low;

	////////////////////////////////////////////////////////////////////
	// Decode

	frae_decode u_decode (
		.instr_valid (INSTR_VALID),
		.instr_word  (INSTR_WORD),
		.op          (op),
		.dest_file   (dest_file),
		.idx         (idx)
	);

	assign is_sum = (op == FRAE_OP_SUM);
	assign is_mask = (op == FRAE_OP_MASK);
	assign exec = is_sum || is_mask;
	assign to_acc = exec && !dest_file;
	assign to_file = exec && dest_file;

	// The register file is read by the raw index field
	assign FILE_RADDR = idx;

	////////////////////////////////////////////////////////////////////
	// Operand fetch
	// The write of the previous word lands only at this clock edge, so a
	// back-to-back word on the same register must see the pending byte.

	assign fwd_hit = wr_pend_reg && (wr_addr_reg == idx);
	assign operand = fwd_hit ? wr_data_reg : FILE_RDATA;

	////////////////////////////////////////////////////////////////////
	// Arithmetic and logic

	assign acc_low = acc_reg[`FRAE_NIB_W-1:0];
	assign opd_low = operand[`FRAE_NIB_W-1:0];

	assign sum_wide = {1'b0, acc_reg} + {1'b0, operand};
	assign nib_wide = {1'b0, acc_low} + {1'b0, opd_low};
	assign mask_res = acc_reg & operand;

	assign result = is_sum ? sum_wide[`FRAE_DATA_W-1:0] : mask_res;
	assign res_zero = (result == `FRAE_BYTE_ZERO);

	////////////////////////////////////////////////////////////////////
	// Next state
	// An executing word owns the accumulator and flags for its cycle; a
	// preload in the same cycle is dropped rather than merged.

	assign acc_next = to_acc ? result :
		(ACC_LOAD && !exec) ? ACC_LOAD_DATA : acc_reg;

	assign carry_next = is_sum ? sum_wide[`FRAE_DATA_W] :
		(FLAG_LOAD && !exec) ? FLAG_LOAD_DATA[`FRAE_FLAG_C] :
		carry_reg;

	assign nib_next = is_sum ? nib_wide[`FRAE_NIB_W] :
		(FLAG_LOAD && !exec) ? FLAG_LOAD_DATA[`FRAE_FLAG_DC] :
		nib_reg;

	assign zero_next = exec ? res_zero :
		FLAG_LOAD ? FLAG_LOAD_DATA[`FRAE_FLAG_Z] : zero_reg;

	////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			acc_reg <= `FRAE_ACC_RST;
		end else begin
			acc_reg <= acc_next;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			carry_reg <= `FRAE_BIT_RST;
			nib_reg <= `FRAE_BIT_RST;
			zero_reg <= `FRAE_BIT_RST;
		end else begin
			carry_reg <= carry_next;
			nib_reg <= nib_next;
			zero_reg <= zero_next;
		end
	end

	// Write stage: one cycle, no queue, since one word retires per cycle
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			wr_pend_reg <= `FRAE_BIT_RST;
			wr_addr_reg <= `FRAE_ADDR_RST;
			wr_data_reg <= `FRAE_ACC_RST;
		end else begin
			wr_pend_reg <= to_file;
			if (to_file) begin
				wr_addr_reg <= idx;
				wr_data_reg <= result;
			end
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			done_reg <= `FRAE_BIT_RST;
		end else begin
			done_reg <= exec;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Outputs

	assign ACC = acc_reg;
	assign CARRY_FLAG = carry_reg;
	assign NIBBLE_CARRY_FLAG = nib_reg;
	assign ZERO_FLAG = zero_reg;
	assign FILE_WE = wr_pend_reg;
	assign FILE_WADDR = wr_addr_reg;
	assign FILE_WDATA = wr_data_reg;
	assign EXEC_DONE = done_reg;

	////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);

	a_decode_sum_word: assert property (
		is_sum == (INSTR_VALID &&
			INSTR_WORD[`FRAE_OPC_MSB:`FRAE_OPC_LSB] == `FRAE_SUM_OPC))
		else $error("add word decoded wrongly");

	a_decode_mask_word: assert property (
		is_mask == (INSTR_VALID &&
			INSTR_WORD[`FRAE_OPC_MSB:`FRAE_OPC_LSB] == `FRAE_MASK_OPC))
		else $error("AND word decoded wrongly");

	a_index_dest_fields: assert property (
		exec |=> (FILE_WE == $past(INSTR_WORD[`FRAE_DEST_BIT]))
			&& (!FILE_WE || FILE_WADDR == $past(FILE_RADDR)))
		else $error("index or destination field misused");

	a_sum_into_acc: assert property (
		(is_sum && !dest_file)
			|=> ACC == $past(acc_reg) + $past(operand))
		else $error("accumulator did not receive the sum");

	a_sum_file_kept: assert property (
		(is_sum && !dest_file) |=> !FILE_WE)
		else $error("register written for accumulator destination");

	a_sum_into_file: assert property (
		(is_sum && dest_file) |=> FILE_WE && $stable(ACC)
			&& FILE_WDATA == $past(acc_reg) + $past(operand)
			&& FILE_WADDR == $past(idx))
		else $error("register did not receive the sum");

	a_sum_carry_out: assert property (
		is_sum |=> CARRY_FLAG ==
			($past(acc_reg) > `FRAE_BYTE_MAX - $past(operand)))
		else $error("carry wrong after add");

	a_sum_nibble_carry: assert property (
		is_sum |=> NIBBLE_CARRY_FLAG ==
			($past(acc_low) > `FRAE_NIB_MAX - $past(opd_low)))
		else $error("nibble carry wrong after add");

	a_zero_acc_dest: assert property (
		to_acc |=> ZERO_FLAG == (ACC == `FRAE_BYTE_ZERO))
		else $error("zero flag disagrees with accumulator");

	a_zero_file_dest: assert property (
		to_file |=> ZERO_FLAG == (FILE_WDATA == `FRAE_BYTE_ZERO))
		else $error("zero flag disagrees with written byte");

	a_mask_into_acc: assert property (
		(is_mask && !dest_file)
			|=> ACC == ($past(acc_reg) & $past(operand)) && !FILE_WE)
		else $error("accumulator did not receive the AND");

	a_mask_into_file: assert property (
		(is_mask && dest_file) |=> FILE_WE && $stable(ACC)
			&& FILE_WDATA == ($past(acc_reg) & $past(operand)))
		else $error("register did not receive the AND");

	a_mask_flags_kept: assert property (
		is_mask |=> $stable(CARRY_FLAG) && $stable(NIBBLE_CARRY_FLAG))
		else $error("AND disturbed carry flags");

	a_done_one_cycle: assert property (
		exec ##1 !exec |-> EXEC_DONE ##1 (!EXEC_DONE && !FILE_WE))
		else $error("operation did not retire in one cycle");

	a_forward_pending: assert property (
		(exec && wr_pend_reg && wr_addr_reg == idx)
			|-> operand == FILE_WDATA)
		else $error("back-to-back operand not forwarded");

	// Zero recomputed from operands, so a broken res_zero cannot hide
	a_sum_zero_flag: assert property (
		is_sum |=> ZERO_FLAG ==
			(8'($past(acc_reg) + $past(operand)) == `FRAE_BYTE_ZERO))
		else $error("zero flag wrong after add");

	a_mask_zero_flag: assert property (
		is_mask |=> ZERO_FLAG ==
			(($past(acc_reg) & $past(operand)) == `FRAE_BYTE_ZERO))
		else $error("zero flag wrong after AND");

	a_read_index: assert property (
		FILE_RADDR == INSTR_WORD[`FRAE_IDX_MSB:`FRAE_IDX_LSB])
		else $error("register read by wrong index");

	a_mask_file_index: assert property (
		(is_mask && dest_file) |=> FILE_WADDR == $past(idx))
		else $error("AND result written to wrong register");

	a_exec_retires: assert property (
		exec |=> EXEC_DONE)
		else $error("executed word did not signal completion");

	a_refused_word_idle: assert property (
		!exec |=> !EXEC_DONE && !FILE_WE)
		else $error("ignored word produced a result");

	a_idle_acc_kept: assert property (
		(!exec && !ACC_LOAD) |=> $stable(ACC))
		else $error("accumulator moved without a word or preload");

	a_load_yields_exec: assert property (
		(to_file && ACC_LOAD) |=> $stable(ACC))
		else $error("preload overrode an executing word");

endmodule

/* File: sim/file_reg_add_and_exec_tb.sv */
/*
 * Self-checking bench for frae_core: an integer model of accumulator,
 * flags and register file runs beside the design, compared every clock.
 * Assumes frae_core answers each word at the next clock edge.
 */
`timescale 1ns/100ps
`include "frae_defs.svh"
module file_reg_add_and_exec_tb;

	// Design connections
	logic                       CORE_CLK;
	logic                       RST_N;
	logic                       INSTR_VALID;
	logic [`FRAE_WORD_W-1:0]    INSTR_WORD;
	logic [`FRAE_IDX_W-1:0]     FILE_RADDR;
	logic [`FRAE_DATA_W-1:0]    FILE_RDATA;
	logic                       FILE_WE;
	logic [`FRAE_IDX_W-1:0]     FILE_WADDR;
	logic [`FRAE_DATA_W-1:0]    FILE_WDATA;
	logic                       ACC_LOAD;
	logic [`FRAE_DATA_W-1:0]    ACC_LOAD_DATA;
	logic                       FLAG_LOAD;
	logic [`FRAE_FLAG_W-1:0]    FLAG_LOAD_DATA;
	logic [`FRAE_DATA_W-1:0]    ACC;
	logic                       CARRY_FLAG;
	logic                       NIBBLE_CARRY_FLAG;
	logic                       ZERO_FLAG;
	logic                       EXEC_DONE;

	// Register file image and model state
	logic [7:0]                 mem [0:127];
	logic [7:0]                 mm [0:127];
	logic [7:0]                 e_acc;
	logic [7:0]                 e_wd;
	logic [6:0]                 e_wa;
	logic [2:0]                 e_fl;
	logic                       e_done;
	logic                       e_we;
	int                         failures = 0;
	int                         n_tests = 0;
	int                         seed_ret;

	frae_core dut (
		.CORE_CLK          (CORE_CLK),
		.RST_N             (RST_N),
		.INSTR_VALID       (INSTR_VALID),
		.INSTR_WORD        (INSTR_WORD),
		.FILE_RADDR        (FILE_RADDR),
		.FILE_RDATA        (FILE_RDATA),
		.FILE_WE           (FILE_WE),
		.FILE_WADDR        (FILE_WADDR),
		.FILE_WDATA        (FILE_WDATA),
		.ACC_LOAD          (ACC_LOAD),
		.ACC_LOAD_DATA     (ACC_LOAD_DATA),
		.FLAG_LOAD         (FLAG_LOAD),
		.FLAG_LOAD_DATA    (FLAG_LOAD_DATA),
		.ACC               (ACC),
		.CARRY_FLAG        (CARRY_FLAG),
		.NIBBLE_CARRY_FLAG (NIBBLE_CARRY_FLAG),
		.ZERO_FLAG         (ZERO_FLAG),
		.EXEC_DONE         (EXEC_DONE)
	);

	// Written one edge late, so only forwarding can match the model
	assign FILE_RDATA = mem[FILE_RADDR];
	always @(posedge CORE_CLK) begin
		if (FILE_WE === 1'b1)
			mem[FILE_WADDR] <= FILE_WDATA;
	end

	initial begin
		CORE_CLK = 1'b0;
		forever #12.5 CORE_CLK = ~CORE_CLK;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_all;
		chk(ACC, e_acc);
		chk({5'h00, ZERO_FLAG, NIBBLE_CARRY_FLAG, CARRY_FLAG}, 8'(e_fl));
		chk({7'h00, EXEC_DONE}, {7'h00, e_done});
		chk({7'h00, FILE_WE}, {7'h00, e_we});
		chk({1'b0, FILE_WADDR}, {1'b0, e_wa});
		chk(FILE_WDATA, e_wd);
	endtask

	task automatic results;
		$display("Counts: failures=%0d tests=%0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic do_reset;
		{RST_N, INSTR_VALID, ACC_LOAD, FLAG_LOAD} = 4'h0;
		repeat (4) @(posedge CORE_CLK);
		#1;
		{e_acc, e_fl, e_done, e_we, e_wa, e_wd} = 28'h000_0000;
		check_all();
		RST_N = 1'b1;
	endtask

	// One cycle: drive, advance the model, then compare after the edge
	task automatic step(input logic v, input logic [13:0] w, input logic al,
			input logic [7:0] ad, input logic fl, input logic [2:0] fd);
		logic [7:0] f;
		logic [7:0] r;
		logic [8:0] s;
		logic [4:0] n;
		logic       sum;
		logic       ex;
		{INSTR_VALID, INSTR_WORD, ACC_LOAD} = {v, w, al};
		{ACC_LOAD_DATA, FLAG_LOAD, FLAG_LOAD_DATA} = {ad, fl, fd};
		sum = v && (w[13:8] == `FRAE_SUM_OPC);
		ex = sum || (v && (w[13:8] == `FRAE_MASK_OPC));
		f = mm[w[6:0]];
		s = {1'b0, e_acc} + {1'b0, f};
		n = {1'b0, e_acc[3:0]} + {1'b0, f[3:0]};
		r = sum ? s[7:0] : (e_acc & f);
		e_done = ex;
		e_we = ex && w[7];
		if (e_we) begin
			mm[w[6:0]] = r;
			{e_wa, e_wd} = {w[6:0], r};
		end
		e_acc = (ex && !w[7]) ? r : ((!ex && al) ? ad : e_acc);
		if (ex)
			e_fl = {r == 8'h00, sum ? {n[4], s[8]} : e_fl[1:0]};
		else if (fl)
			e_fl = fd;
		#1;
		chk({1'b0, FILE_RADDR}, {1'b0, w[6:0]});
		@(posedge CORE_CLK);
		#1;
		check_all();
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		logic [31:0] r;
		logic [5:0]  op;
		logic [6:0]  idx;
		{INSTR_WORD, ACC_LOAD_DATA, FLAG_LOAD_DATA} = 25'h000_0000;
		seed_ret = $urandom(32'h3119_ec3f);
		for (int i = 0; i < 128; i++)
			mem[i] = 8'($urandom);
		mem[5] = 8'hC2;
		mm = mem;
		do_reset();
		step(1'b0, 14'h0000, 1'b1, 8'h17, 1'b1, 3'h0);
		step(1'b1, 14'h0785, 1'b0, 8'h00, 1'b0, 3'h0);
		step(1'b1, 14'h0585, 1'b1, 8'hAA, 1'b0, 3'h0);
		step(1'b1, 14'h0505, 1'b0, 8'h00, 1'b1, 3'h7);
		step(1'b0, 14'h0000, 1'b1, 8'hEF, 1'b0, 3'h0);
		step(1'b1, 14'h0705, 1'b0, 8'h00, 1'b0, 3'h0);
		// Narrow indices half the time so words collide on one register
		for (int i = 0; i < 2000; i++) begin
			if (i == 1000)
				do_reset();
			r = $urandom;
			idx = r[0] ? {5'h00, r[2:1]} : r[15:9];
			op = (r[18:17] == 2'd0) ? `FRAE_SUM_OPC :
				((r[18:17] == 2'd1) ? `FRAE_MASK_OPC : r[24:19]);
			step(r[31:29] != 3'd0, {op, r[16], idx}, r[25] & r[26],
				8'($urandom), r[27] & r[28], r[10:8]);
		end
		results();
	end

	initial begin
		#(25 * 3000);
		failures++;
		results();
	end

endmodule
